// *** src/ssb_pkg.sv ***
// package: constants and carriers for the shared sram bank decode block
package ssb_pkg;
  // address space and data widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 24;
  localparam int LANE_W = 8;
  localparam int LANES = 3;
  localparam int MEM_AW = 17;
  localparam int HALF_BIT = 16;
  // attribute config field layout
  localparam int ACC_LO = 0;
  localparam int POL_BIT = 2;
  localparam int P_BIT = 3;
  localparam int X_BIT = 4;
  localparam int Y_BIT = 5;
  localparam int NADD_LO = 8;
  localparam int BASE_LO = 12;
  localparam int BASE_W = 12;
  localparam logic [1:0] ACC_ASRAM = 2'h1;
  // reset values of the two configs and the wait control
  localparam logic [23:0] CFG3_RST = 24'h100739;
  localparam logic [23:0] CFG2_RST = 24'h11083D;
  localparam logic [23:0] BWC_RST = 24'h002400;
  // wait control fields
  localparam int WS2_LO = 10;
  localparam int WS3_LO = 13;
  localparam int WSD_LO = 16;
  // bank range
  localparam logic [23:0] BANK_LO = 24'h100000;
  localparam logic [23:0] BANK_HI = 24'h120000;
  // space codes
  localparam logic [1:0] SP_P = 2'h0;
  localparam logic [1:0] SP_X = 2'h1;
  localparam logic [1:0] SP_Y = 2'h2;
  // register offsets (byte addresses)
  localparam logic [3:0] OFS_CFG2 = 4'h0;
  localparam logic [3:0] OFS_CFG3 = 4'h4;
  localparam logic [3:0] OFS_BWC = 4'h8;
  localparam logic [3:0] OFS_MODE = 4'hC;
  // timing: memory access time and core rate
  localparam real T_ACC_NS = 12.4;
  localparam real CLK_NS = 25.0;
  localparam int ACC_CYC = (T_ACC_NS / CLK_NS) > 1.0 ? int'($ceil(T_ACC_NS / CLK_NS)) : 1;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [1:0] space;
    logic [DATA_W-1:0] wdata;
  } ssb_req_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } ssb_state_e;
endpackage

// *** src/ssb_lane_mem.sv ***
// the bank's byte-lane memory arrays, one per lane of the word, registered read data
`timescale 1ns/10ps
`default_nettype none
module ssb_lane_mem #(
  parameter int AW = 17,
  parameter int W = 24,
  parameter int LW = 8
) (
  input wire logic clk,
  input wire logic cs,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata
);
  genvar g;
  generate
    for (g = 0; g < W / LW; g++) begin : g_lane
      logic [LW-1:0] mem [0:(1<<AW)-1];
      always_ff @(posedge clk) begin
        if (cs && we) begin
          mem[addr] <= wdata[g*LW +: LW];
        end
        if (cs && !we) begin
          rdata[g*LW +: LW] <= mem[addr];
        end
      end
    end
  endgenerate
endmodule // ssb_lane_mem
`default_nettype wire

// *** src/ssb_top.sv ***
// shared sram bank decode: attribute selects, wait states, bank storage
//
// Function
// - shared bank returns same word in any space when both selectors enable the same spaces
// - route $100000-$11FFFF accesses to the bank
// - three byte lanes form one full word
// - single-selector mode uses A16 for top address
// - each bank access lasts its area's wait count, area 3's where both areas hit, one wait state at reset
// - one selector maps bank to any space mix
// - two selectors allow 64K split arrangements
// - config holds type, polarity, P/X/Y enables
// - select only when masked upper bits match base
// - wait control holds count per attribute area
`timescale 1ns/10ps
`default_nettype none
module ssb_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // core memory request
  input wire logic CORE_RD,
  input wire logic CORE_WR,
  input wire logic [23:0] CORE_ADDR,
  input wire logic [1:0] CORE_SPACE,
  input wire logic [23:0] CORE_WDATA,
  output logic [23:0] CORE_RDATA,
  output logic CORE_ACK,
  output logic CORE_MISS,
  // attribute select pins
  output logic ATTRIBUTE_SELECT_2,
  output logic ATTRIBUTE_SELECT_3
);
  typedef struct packed {
    ssb_pkg::ssb_state_e st;
    logic [23:0] cfg2;
    logic [23:0] cfg3;
    logic [23:0] bwc;
    logic single_sel;
    logic [4:0] wcnt;
    ssb_pkg::ssb_req_s req;
    logic sel2;
    logic sel3;
    logic ack;
    logic miss;
    logic [23:0] rdata;
    logic [31:0] avs_rdata;
    logic avs_wait;
    logic avs_done;
  } ssb_state_s;

  ssb_state_s s_q, s_d;
  logic [23:0] mem_rdata;
  logic mem_cs, mem_we;
  logic [16:0] mem_addr;
  logic hit2, hit3, in_bank;

  // attribute match: space enable plus masked base compare
  function automatic logic attr_hit(input logic [23:0] cfg, input logic [23:0] a, input logic [1:0] sp);
    logic [11:0] mask;
    logic en;
    logic [3:0] n;
    mask = 12'h000;
    n = cfg[ssb_pkg::NADD_LO +: 4];
    for (int i = 0; i < ssb_pkg::BASE_W; i++) begin
      if (i >= ssb_pkg::BASE_W - int'(n)) begin
        mask[i] = 1'b1;
      end
    end
    case (sp)
      ssb_pkg::SP_P: en = cfg[ssb_pkg::P_BIT];
      ssb_pkg::SP_X: en = cfg[ssb_pkg::X_BIT];
      ssb_pkg::SP_Y: en = cfg[ssb_pkg::Y_BIT];
      default: en = 1'b0;
    endcase
    attr_hit = en && (cfg[ssb_pkg::ACC_LO +: 2] == ssb_pkg::ACC_ASRAM)
      && (((a[ssb_pkg::ADDR_W-1 -: ssb_pkg::BASE_W] ^ cfg[ssb_pkg::BASE_LO +: ssb_pkg::BASE_W]) & mask) == 12'h000);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode of the held request
  always_comb begin
    in_bank = (s_q.req.addr >= ssb_pkg::BANK_LO) && (s_q.req.addr < ssb_pkg::BANK_HI);
    hit3 = attr_hit(s_q.cfg3, s_q.req.addr, s_q.req.space) && in_bank;
    hit2 = attr_hit(s_q.cfg2, s_q.req.addr, s_q.req.space) && in_bank && !s_q.single_sel;
    // space code reaches the array only through hit2 in two-selector mode; otherwise all spaces share words
    mem_addr = {s_q.single_sel ? s_q.req.addr[ssb_pkg::HALF_BIT] : hit2, s_q.req.addr[ssb_pkg::HALF_BIT-1:0]};
    mem_cs = (s_q.st == ssb_pkg::ST_WAIT) && (s_q.wcnt == 5'h00) && (hit2 || hit3);
    mem_we = s_q.req.wr;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.miss = 1'b0;
    s_d.avs_wait = 1'b1;
    s_d.avs_done = 1'b0;
    // avalon slave: one wait cycle, then answer
    if ((AVS_READ || AVS_WRITE) && !s_q.avs_done && s_q.avs_wait) begin
      s_d.avs_wait = 1'b0;
      s_d.avs_done = 1'b1;
      case (AVS_ADDRESS)
        ssb_pkg::OFS_CFG2: s_d.avs_rdata = {8'h00, s_q.cfg2};
        ssb_pkg::OFS_CFG3: s_d.avs_rdata = {8'h00, s_q.cfg3};
        ssb_pkg::OFS_BWC: s_d.avs_rdata = {8'h00, s_q.bwc};
        ssb_pkg::OFS_MODE: s_d.avs_rdata = {31'h0, s_q.single_sel};
        default: s_d.avs_rdata = 32'h00000000;
      endcase
    end
    // a write lands only at the edge that completes the transfer
    if (AVS_WRITE && s_q.avs_done) begin
      case (AVS_ADDRESS)
        ssb_pkg::OFS_CFG2: s_d.cfg2 = AVS_WRITEDATA[23:0];
        ssb_pkg::OFS_CFG3: s_d.cfg3 = AVS_WRITEDATA[23:0];
        ssb_pkg::OFS_BWC: s_d.bwc = AVS_WRITEDATA[23:0];
        ssb_pkg::OFS_MODE: s_d.single_sel = AVS_WRITEDATA[0];
        default: s_d.single_sel = s_q.single_sel;
      endcase
    end
    case (s_q.st)
      ssb_pkg::ST_IDLE: begin
        // idle level is the inactive one for the programmed polarity, so no memory is enabled
        s_d.sel2 = !s_q.cfg2[ssb_pkg::POL_BIT];
        s_d.sel3 = !s_q.cfg3[ssb_pkg::POL_BIT];
        if (CORE_RD || CORE_WR) begin
          s_d.req.rd = CORE_RD && !CORE_WR;
          s_d.req.wr = CORE_WR;
          s_d.req.addr = CORE_ADDR;
          s_d.req.space = CORE_SPACE;
          s_d.req.wdata = CORE_WDATA;
          s_d.wcnt = 5'h00;
          s_d.st = ssb_pkg::ST_WAIT;
        end
      end
      ssb_pkg::ST_WAIT: begin
        if (!(hit2 || hit3)) begin
          s_d.miss = 1'b1;
          s_d.ack = 1'b1;
          s_d.st = ssb_pkg::ST_IDLE;
        end else if (s_q.wcnt == 5'h00) begin
          // select pin polarity from config
          s_d.sel3 = hit3 ^ !s_q.cfg3[ssb_pkg::POL_BIT];
          s_d.sel2 = hit2 ^ !s_q.cfg2[ssb_pkg::POL_BIT];
          s_d.wcnt = hit3 ? {2'b00, s_q.bwc[ssb_pkg::WS3_LO +: 3]} : {2'b00, s_q.bwc[ssb_pkg::WS2_LO +: 3]};
          if (s_d.wcnt == 5'h00) s_d.st = ssb_pkg::ST_DONE;
        end else begin
          s_d.wcnt = s_q.wcnt - 5'h01;
          if (s_q.wcnt == 5'h01) s_d.st = ssb_pkg::ST_DONE;
        end
      end
      ssb_pkg::ST_DONE: begin
        s_d.rdata = mem_rdata;
        s_d.ack = 1'b1;
        s_d.sel2 = !s_q.cfg2[ssb_pkg::POL_BIT];
        s_d.sel3 = !s_q.cfg3[ssb_pkg::POL_BIT];
        s_d.st = ssb_pkg::ST_IDLE;
      end
      default: s_d.st = ssb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.cfg2 <= ssb_pkg::CFG2_RST;
      s_q.cfg3 <= ssb_pkg::CFG3_RST;
      s_q.bwc <= ssb_pkg::BWC_RST;
      s_q.avs_wait <= 1'b1;
      s_q.sel2 <= !ssb_pkg::CFG2_RST[ssb_pkg::POL_BIT];
      s_q.sel3 <= !ssb_pkg::CFG3_RST[ssb_pkg::POL_BIT];
      s_q.st <= ssb_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bank storage: three lanes share address and controls
  ssb_lane_mem #(.AW(ssb_pkg::MEM_AW), .W(ssb_pkg::DATA_W), .LW(ssb_pkg::LANE_W)) u_mem (
    .clk(CLOCK),
    .cs(mem_cs),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(s_q.req.wdata),
    .rdata(mem_rdata)
  );

  // outputs from flip-flops; idle pins read inactive via polarity
  assign AVS_READDATA = s_q.avs_rdata;
  assign AVS_WAITREQUEST = s_q.avs_wait;
  assign CORE_RDATA = s_q.rdata;
  assign CORE_ACK = s_q.ack;
  assign CORE_MISS = s_q.miss;
  assign ATTRIBUTE_SELECT_2 = s_q.sel2;
  assign ATTRIBUTE_SELECT_3 = s_q.sel3;

  ////////////////////////////////////////////////////////////////////////
  a_miss_outside: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_q.st == ssb_pkg::ST_WAIT && !in_bank) |=> (CORE_ACK && CORE_MISS))
    else $error("out of range access not refused");
  a_one_wait: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_q.st == ssb_pkg::ST_WAIT && mem_cs && s_q.bwc[ssb_pkg::WS3_LO +: 3] == 3'h1 && hit3)
      |=> (s_q.st == ssb_pkg::ST_WAIT) ##1 (s_q.st == ssb_pkg::ST_DONE) ##1 CORE_ACK)
    else $error("bank access not one wait state");
  a_ack_pulse: assert property (@(posedge CLOCK) disable iff (!RST_B)
    CORE_ACK |=> !CORE_ACK)
    else $error("ack longer than one cycle");
  a_sel_idle: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ($past(s_q.st) == ssb_pkg::ST_DONE)
      |-> (ATTRIBUTE_SELECT_3 == !s_q.cfg3[ssb_pkg::POL_BIT] && ATTRIBUTE_SELECT_2 == !s_q.cfg2[ssb_pkg::POL_BIT]))
    else $error("select not released after access");
  a_single_top: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_q.single_sel && mem_cs) |-> (mem_addr[16] == s_q.req.addr[16]))
    else $error("single selector top bit not from address");
  a_sel2_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_q.single_sel && s_q.st != ssb_pkg::ST_IDLE) |-> (ATTRIBUTE_SELECT_2 == !s_q.cfg2[ssb_pkg::POL_BIT]))
    else $error("second selector active in single mode");
  a_avs_answer: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !s_q.avs_done) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer timing wrong");
  a_type_gate: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_q.st == ssb_pkg::ST_WAIT && s_q.wcnt == 5'h00 && !hit2
      && s_q.cfg3[ssb_pkg::ACC_LO +: 2] != ssb_pkg::ACC_ASRAM) |=> CORE_MISS)
    else $error("select with wrong access type");
endmodule // ssb_top
`default_nettype wire

// *** verification/ssb_sram_watch.sv ***
// far-side watch of one select pin: the half select that feeds the bank's top address, or the bank enable
`timescale 1ns/10ps
`default_nettype none
module ssb_sram_watch (
  // clock
  input wire logic clk,
  // select pin from the block
  input wire logic sel,
  // cycles seen selected
  output logic [15:0] act_cnt
);
  logic [15:0] cnt_q = 16'h0000;
  assign act_cnt = cnt_q;
  // counts only a solid high, so an unknown pin never looks selected
  always @(posedge clk) begin
    if (sel === 1'b1) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // ssb_sram_watch
`default_nettype wire

// *** verification/shared_sram_bank_decode_test.sv ***
// self-checking bench for the shared sram bank decode block
`timescale 1ns/10ps
`default_nettype none
module shared_sram_bank_decode_test;
  logic clk = 0, rst_b = 0, a_rd = 0, a_wr = 0, c_rd = 0, c_wr = 0, hi2, hi3;
  logic [3:0] a_adr = 0;
  logic [31:0] a_wd = 0, a_rdat, v;
  logic [23:0] c_adr = 0, c_wd = 0, c_rdat;
  logic [1:0] c_sp = 0;
  logic a_wait, c_ack, c_miss, sel2, sel3;
  logic [15:0] n2, n3, p, p3;
  logic [3:0] adr_t [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1};
  logic [31:0] rst_t [5] = '{32'h0011083D, 32'h00100739, 32'h00002400, 32'h0, 32'h0};
  logic [23:0] ra [3] = '{24'h0FFFFF, 24'h11FFFF, 24'h120000};
  // miss, upper-half select seen, bank select seen, edges to ack
  logic [6:0] rx [3] = '{7'h42, 7'h34, 7'h42};
  int err_count = 0, total_checks = 0, n;
  ssb_top u_dut (.CLOCK(clk), .RST_B(rst_b), .AVS_ADDRESS(a_adr), .AVS_READ(a_rd), .AVS_WRITE(a_wr),
    .AVS_WRITEDATA(a_wd), .AVS_READDATA(a_rdat), .AVS_WAITREQUEST(a_wait), .CORE_RD(c_rd), .CORE_WR(c_wr),
    .CORE_ADDR(c_adr), .CORE_SPACE(c_sp), .CORE_WDATA(c_wd), .CORE_RDATA(c_rdat), .CORE_ACK(c_ack),
    .CORE_MISS(c_miss), .ATTRIBUTE_SELECT_2(sel2), .ATTRIBUTE_SELECT_3(sel3));
  ssb_sram_watch u_far (.clk(clk), .sel(sel2), .act_cnt(n2));
  // bank enable pin is active low with the reset polarity
  ssb_sram_watch u_far3 (.clk(clk), .sel(!sel3), .act_cnt(n3));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // register access; values sampled here are those standing before the edge
  task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    a_adr <= ad;
    a_wd <= d;
    a_rd <= !w;
    a_wr <= w;
    do begin
      @(posedge clk);
    end while (a_wait !== 1'b0);
    v = a_rdat;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
  endtask
  // core access as a one-cycle pulse; n counts edges from the take to ack
  task automatic cx(input logic w, input logic [1:0] sp, input logic [23:0] ad, input logic [23:0] d);
    n = 0;
    @(posedge clk);
    c_rd <= !w;
    c_wr <= w;
    c_sp <= sp;
    c_adr <= ad;
    c_wd <= d;
    @(posedge clk);
    c_rd <= 1'b0;
    c_wr <= 1'b0;
    p = n2;
    p3 = n3;
    do begin
      @(posedge clk);
      n++;
    end while (c_ack !== 1'b1);
    hi2 = (n2 != p);
    hi3 = (n3 != p3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({a_wait, c_ack, c_miss, sel2, sel3}, 5'b10001);
    for (int i = 0; i < 5; i++) begin
      av(1'b0, adr_t[i], 32'h0);
      chk(v, rst_t[i]);
    end
    $display("test reset values done");
    cx(1'b1, 2'h0, 24'h100000, 24'h012345);
    chk(n, 4);
    for (int s = 0; s < 3; s++) begin
      cx(1'b0, s[1:0], 24'h100000, 24'h0);
      chk({c_miss, hi3, c_rdat}, {1'b0, 1'b1, 24'h012345});
    end
    chk({sel2, sel3}, 2'b01);
    $display("test shared word done");
    for (int i = 0; i < 3; i++) begin
      cx(1'b0, 2'h2, ra[i], 24'h0);
      chk({c_miss, hi2, hi3, n[3:0]}, rx[i]);
    end
    $display("test bank range done");
    for (int m = 1; m < 8; m++) begin
      av(1'b1, 4'h4, 32'h00100701 | (m << 3));
      for (int s = 0; s < 3; s++) begin
        cx(1'b0, s[1:0], 24'h100010, 24'h0);
        chk(c_miss, !m[s]);
      end
    end
    // access type other than asynchronous sram must never select
    av(1'b1, 4'h4, 32'h00100738);
    cx(1'b0, 2'h0, 24'h100010, 24'h0);
    chk({c_miss, hi3}, 2'b10);
    av(1'b1, 4'h4, 32'h00100739);
    $display("test space mixes done");
    // area 3 raised to two wait states costs one more cycle
    av(1'b1, 4'h8, 32'h00004400);
    av(1'b0, 4'h8, 32'h0);
    chk(v, 32'h00004400);
    cx(1'b0, 2'h1, 24'h100000, 24'h0);
    chk(n, 5);
    av(1'b1, 4'h8, 32'h00002400);
    $display("test wait states done");
    // upper half given to y only, so x at the same address falls into the lower half
    av(1'b1, 4'h0, 32'h00110825);
    cx(1'b1, 2'h2, 24'h110000, 24'h555555);
    cx(1'b1, 2'h1, 24'h110000, 24'hAAAAAA);
    cx(1'b0, 2'h2, 24'h110000, 24'h0);
    chk(c_rdat, 24'h555555);
    cx(1'b0, 2'h0, 24'h100000, 24'h0);
    chk(c_rdat, 24'hAAAAAA);
    av(1'b1, 4'hC, 32'h1);
    cx(1'b1, 2'h1, 24'h110000, 24'h2BAD2C);
    cx(1'b0, 2'h2, 24'h110000, 24'h0);
    chk(c_rdat, 24'h2BAD2C);
    $display("test half split done");
    test_done;
  end
endmodule // shared_sram_bank_decode_test
`default_nettype wire
